// [design/bridge_err_pkg.sv]
// package: register map, field positions and reset values of the bridge error block
package bridge_err_pkg;
  localparam logic [7:0] OFF_COMMAND     = 8'h04;
  localparam logic [7:0] OFF_PRI_STATUS  = 8'h06;
  localparam logic [7:0] OFF_SEC_STATUS  = 8'h1e;
  localparam logic [7:0] OFF_BRIDGE_CTRL = 8'h3e;
  localparam logic [7:0] OFF_EVENT_MASK  = 8'h64;
  localparam logic [7:0] OFF_EVENT_STAT  = 8'h6a;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h80;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h84;
  // register indexes: printed offsets are not all word multiples, so the
  // byte address on the bus is four times the index
  localparam int CMD_PERR_BIT  = 6;
  localparam int CMD_SERR_BIT  = 8;
  localparam int ST_DPE_BIT    = 15;
  localparam int ST_SSE_BIT    = 14;
  localparam int ST_MDPE_BIT   = 8;
  localparam int BC_PERR_BIT   = 0;
  localparam int BC_SERR_BIT   = 1;
  localparam int BC_PRI_DISCARD_BIT = 8;
  localparam int BC_SEC_DISCARD_BIT = 9;
  // event bit positions
  localparam int EV_TABORT     = 0;
  localparam int EV_MABORT     = 1;
  localparam int EV_PW_DISCARD = 2;
  localparam int EV_PW_PARITY  = 3;
  localparam int EV_DW_DISCARD = 4;
  localparam int EV_DR_FAIL    = 5;
  localparam int EV_DT_TIMEOUT = 6;
  localparam int NUM_EVENTS    = 7;
  localparam logic [15:0] COMMAND_RESET = 16'h0000;
  localparam logic [15:0] BCTRL_RESET   = 16'h0000;
  localparam logic [7:0]  MASK_RESET    = 8'h00;
  // interrupt sources
  localparam int IRQ_PRI_ADDR = 0;
  localparam int IRQ_SEC_ADDR = 1;
  localparam int IRQ_DATA     = 2;
  localparam int IRQ_SERR_OUT = 3;
  localparam int IRQ_SEC_SERR = 4;
  localparam int NUM_IRQ      = 5;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage

// [design/parity_checker.sv]
// even parity check of one bus phase: address/data plus byte enables against par
`timescale 1ns/1ps
`default_nettype none
module parity_checker #(
  parameter int WIDTH = 36
) (
  // phase sample
  input  wire logic [WIDTH-1:0] bits_i,
  input  wire logic             par_i,
  input  wire logic             valid_i,
  // result
  output logic                  error_o
);
  if (WIDTH < 2)
  begin
    $error("parity_checker width too small");
  end
  // pci par gives even parity over ad and c/be together
  assign error_o = valid_i & ((^bits_i) ^ par_i);
endmodule
`default_nettype wire

// [design/bridge_err_report.sv]
// parity and system error detection and reporting with ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
module bridge_err_report
#(
  parameter int DISCARD_SHORT = 1024,
  parameter int DISCARD_LONG  = 32768
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // ahb-lite slave
  input  wire logic                 hsel_i,
  input  wire logic [9:0]           haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic [31:0]               hrdata_o,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  // primary bus phase sample
  input  wire logic [35:0]          pri_phase_i,
  input  wire logic                 pri_par_i,
  input  wire logic                 pri_addr_valid_i,
  input  wire logic                 pri_data_valid_i,
  input  wire logic                 pri_hit_i,
  input  wire logic                 pri_master_i,
  input  wire logic                 pri_perr_seen_i,
  // secondary bus phase sample
  input  wire logic [35:0]          sec_phase_i,
  input  wire logic                 sec_par_i,
  input  wire logic                 sec_addr_valid_i,
  input  wire logic                 sec_hit_i,
  input  wire logic                 sec_serr_i,
  // forwarding engine events
  input  wire logic [bridge_err_pkg::NUM_EVENTS-1:0] fwd_event_i,
  input  wire logic                 dr_head_i,
  input  wire logic                 dr_repeat_i,
  // outputs to the pins and forwarding path
  output logic                      primary_device_select_o,
  output logic                      secondary_device_select_o,
  output logic                      perr_o,
  output logic                      primary_system_error_pin_o,
  output logic                      fwd_par_o,
  output logic                      dr_discard_o,
  output logic                      irq_o
);
  import bridge_err_pkg::*;

  // the discard counter is 16 bits wide
  if (DISCARD_SHORT < 1 || DISCARD_LONG < DISCARD_SHORT || DISCARD_LONG > 65535)
  begin
    $error("bridge_err_report: bad discard timer length");
  end

  typedef struct packed {
    logic [15:0]           command;
    logic [15:0]           pri_status;
    logic [15:0]           sec_status;
    logic [15:0]           bctrl;
    logic [7:0]            ev_mask;
    logic [7:0]            ev_status;
    logic [NUM_IRQ-1:0]    irq_status;
    logic [NUM_IRQ-1:0]    irq_mask;
    logic                  dp_pend;
    logic                  dp_write;
    logic [7:0]            dp_addr;
    logic [31:0]           rdata;
    logic                  pdevsel;
    logic                  sdevsel;
    logic                  perr;
    logic                  serr;
    logic                  fwd_par;
    logic                  dr_run;
    logic [15:0]           dr_cnt;
    logic                  dr_discard;
    logic                  irq;
    logic                  hready;
    logic                  hresp;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   pri_err;
  logic   sec_err;

  // parity on address and data phases of the primary bus, on address phases only of the secondary bus
  parity_checker #(.WIDTH(36)) u_pri_chk (
    .bits_i  (pri_phase_i),
    .par_i   (pri_par_i),
    .valid_i (pri_addr_valid_i | pri_data_valid_i),
    .error_o (pri_err)
  );
  parity_checker #(.WIDTH(36)) u_sec_chk (
    .bits_i  (sec_phase_i),
    .par_i   (sec_par_i),
    .valid_i (sec_addr_valid_i),
    .error_o (sec_err)
  );

  function automatic logic [15:0] w1c(input logic [15:0] cur, input logic [15:0] clr,
                                      input logic [15:0] set);
    begin
      // set wins over a clear in the same cycle
      w1c = (cur & ~clr) | set;
    end
  endfunction

  always_comb
  begin
    logic        pa_err;
    logic        da_err;
    logic        sa_err;
    logic        secondary_parity_response_enable;
    logic        secondary_error_forward_enable;
    logic        serr_req;
    logic        dr_exp;
    logic        wr;
    logic [15:0] wd;
    logic [15:0] p_set;
    logic [15:0] s_set;
    logic [7:0]  e_set;
    logic [NUM_IRQ-1:0] i_set;
    logic [15:0] dr_len;
    logic [NUM_EVENTS-1:0] ev_all;
    s_d      = s_q;
    pa_err   = pri_err & pri_addr_valid_i;
    da_err   = pri_err & pri_data_valid_i & ~pri_addr_valid_i;
    sa_err   = sec_err;
    secondary_parity_response_enable  = s_q.command[CMD_PERR_BIT];
    secondary_error_forward_enable  = s_q.command[CMD_SERR_BIT];
    p_set    = 16'h0000;
    s_set    = 16'h0000;
    e_set    = 8'h00;
    i_set    = '0;
    wr       = s_q.dp_pend & s_q.dp_write;
    wd       = hwdata_i[15:0];
    // zero wait states and always okay: no access can fail here
    s_d.hready = 1'b1;
    s_d.hresp  = 1'b0;

    // discard timer of the delayed read at queue head
    dr_len = (s_q.bctrl[BC_PRI_DISCARD_BIT] | s_q.bctrl[BC_SEC_DISCARD_BIT]) ?
             DISCARD_SHORT[15:0] : DISCARD_LONG[15:0];
    dr_exp = 1'b0;
    if (!dr_head_i || dr_repeat_i)
    begin
      s_d.dr_run = 1'b0;
      s_d.dr_cnt = 16'h0000;
    end
    else if (!s_q.dr_run)
    begin
      s_d.dr_run = 1'b1;
      s_d.dr_cnt = dr_len - 16'h0001;
    end
    else if (s_q.dr_cnt == 16'h0000)
    begin
      dr_exp     = 1'b1;
      s_d.dr_run = 1'b0;
    end
    else
      s_d.dr_cnt = s_q.dr_cnt - 16'h0001;
    s_d.dr_discard = dr_exp;

    ev_all = fwd_event_i;
    ev_all[EV_DT_TIMEOUT] = fwd_event_i[EV_DT_TIMEOUT] | dr_exp;
    // one sticky status bit per condition
    e_set[NUM_EVENTS-1:0] = ev_all;

    // claims withheld on bad address when parity response is on
    s_d.pdevsel = pri_hit_i & ~(pa_err & secondary_parity_response_enable);
    s_d.sdevsel = sec_hit_i & ~(sa_err & s_q.bctrl[BC_PERR_BIT]);

    if (pa_err || da_err)
      p_set[ST_DPE_BIT] = 1'b1;
    if (sa_err)
      s_set[ST_DPE_BIT] = 1'b1;
    s_d.perr = da_err & secondary_parity_response_enable;
    if (secondary_parity_response_enable && (da_err || (pri_master_i && pri_perr_seen_i)))
      p_set[ST_MDPE_BIT] = 1'b1;
    if (sec_serr_i)
      s_set[ST_SSE_BIT] = 1'b1;

    // every system error source is gated by the enable
    serr_req = secondary_error_forward_enable & ((pa_err & secondary_parity_response_enable)
             | (sa_err & s_q.bctrl[BC_PERR_BIT])
             | (sec_serr_i & s_q.bctrl[BC_SERR_BIT])
             | (|(ev_all & ~s_q.ev_mask[NUM_EVENTS-1:0])));
    s_d.serr = serr_req;
    if (serr_req)
      p_set[ST_SSE_BIT] = 1'b1;

    // keep the received parity bit as is for the far side
    s_d.fwd_par = pri_data_valid_i ? pri_par_i : s_q.fwd_par;

    i_set[IRQ_PRI_ADDR] = pa_err;
    i_set[IRQ_SEC_ADDR] = sa_err;
    i_set[IRQ_DATA]     = da_err;
    i_set[IRQ_SERR_OUT] = serr_req;
    i_set[IRQ_SEC_SERR] = sec_serr_i;

    // register writes, one data phase after the address phase
    s_d.pri_status = w1c(s_q.pri_status, 16'h0000, p_set);
    s_d.sec_status = w1c(s_q.sec_status, 16'h0000, s_set);
    s_d.ev_status  = s_q.ev_status | e_set;
    s_d.irq_status = s_q.irq_status | i_set;
    if (wr)
    begin
      case (s_q.dp_addr)
        OFF_COMMAND:     s_d.command = wd;
        OFF_BRIDGE_CTRL: s_d.bctrl = wd;
        OFF_EVENT_MASK:  s_d.ev_mask = wd[7:0];
        OFF_IRQ_MASK:    s_d.irq_mask = wd[NUM_IRQ-1:0];
        OFF_PRI_STATUS:  s_d.pri_status = w1c(s_q.pri_status, wd, p_set);
        OFF_SEC_STATUS:  s_d.sec_status = w1c(s_q.sec_status, wd, s_set);
        OFF_EVENT_STAT:  s_d.ev_status = (s_q.ev_status & ~wd[7:0]) | e_set;
        OFF_IRQ_STATUS:  s_d.irq_status = (s_q.irq_status & ~wd[NUM_IRQ-1:0]) | i_set;
        default:         s_d.rdata = s_q.rdata;
      endcase
    end

    // address phase capture; read data prepared for the next cycle
    s_d.dp_pend = 1'b0;
    s_d.rdata   = 32'h0000_0000;
    if (hsel_i && hready_i && htrans_i == HTRANS_NONSEQ)
    begin
      s_d.dp_pend  = 1'b1;
      s_d.dp_write = hwrite_i;
      s_d.dp_addr  = haddr_i[9:2];
      if (!hwrite_i)
      begin
        case (haddr_i[9:2])
          OFF_COMMAND:     s_d.rdata = {16'h0000, s_q.command};
          OFF_PRI_STATUS:  s_d.rdata = {16'h0000, s_q.pri_status};
          OFF_SEC_STATUS:  s_d.rdata = {16'h0000, s_q.sec_status};
          OFF_BRIDGE_CTRL: s_d.rdata = {16'h0000, s_q.bctrl};
          OFF_EVENT_MASK:  s_d.rdata = {24'h000000, s_q.ev_mask};
          OFF_EVENT_STAT:  s_d.rdata = {24'h000000, s_q.ev_status};
          OFF_IRQ_STATUS:  s_d.rdata = {27'h0000000, s_q.irq_status};
          OFF_IRQ_MASK:    s_d.rdata = {27'h0000000, s_q.irq_mask};
          default:         s_d.rdata = 32'h0000_0000;
        endcase
      end
    end
    s_d.irq = |(s_d.irq_status & s_d.irq_mask);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_q            <= '0;
      s_q.command    <= COMMAND_RESET;
      s_q.bctrl      <= BCTRL_RESET;
      s_q.ev_mask    <= MASK_RESET;
      s_q.hready     <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign hrdata_o                   = s_q.rdata;
  assign hreadyout_o                = s_q.hready;
  assign hresp_o                    = s_q.hresp;
  assign primary_device_select_o    = s_q.pdevsel;
  assign secondary_device_select_o  = s_q.sdevsel;
  assign perr_o                     = s_q.perr;
  assign primary_system_error_pin_o = s_q.serr;
  assign fwd_par_o                  = s_q.fwd_par;
  assign dr_discard_o               = s_q.dr_discard;
  assign irq_o                      = s_q.irq;
endmodule
`default_nettype wire

// [test/bridge_err_checker.sv]
// checker: claim, parity and system error relations at the block ports
`timescale 1ns/1ps
`default_nettype none
module bridge_err_checker
  import bridge_err_pkg::*;
(
  input wire logic        clk_i, rst_n_i, hsel_i, hwrite_i, hready_i,
  input wire logic [9:0]  haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic [31:0] hwdata_i,
  input wire logic [35:0] pri_phase_i, sec_phase_i,
  input wire logic        pri_par_i, pri_addr_valid_i, pri_data_valid_i, pri_hit_i,
  input wire logic        sec_par_i, sec_addr_valid_i, sec_hit_i, sec_serr_i,
  input wire logic        primary_device_select_o, secondary_device_select_o,
  input wire logic        perr_o, primary_system_error_pin_o
);
  // enables shadowed from observed writes; exact because the slave never waits
  logic        wa_q;
  logic [7:0]  wad_q;
  logic [15:0] cmd_q, bc_q;
  wire logic pbad = ^pri_phase_i ^ pri_par_i;
  wire logic sbad = ^sec_phase_i ^ sec_par_i;
  wire logic dbad = pri_data_valid_i & pbad;
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      wa_q <= 1'b0;
      wad_q <= 8'h00;
      cmd_q <= 16'h0000;
      bc_q <= 16'h0000;
    end
    else
    begin
      wa_q <= hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && hwrite_i;
      wad_q <= haddr_i[9:2];
      if (wa_q && wad_q == OFF_COMMAND) cmd_q <= hwdata_i[15:0];
      if (wa_q && wad_q == OFF_BRIDGE_CTRL) bc_q <= hwdata_i[15:0];
    end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_pri_bad;
    pri_addr_valid_i && pri_hit_i && pbad;
  endsequence
  sequence s_sec_bad;
    sec_addr_valid_i && sec_hit_i && sbad;
  endsequence
  a_pri_claim_ok: assert property (pri_addr_valid_i && pri_hit_i && !pbad
    |=> primary_device_select_o) else $error("clean primary address not claimed");
  a_pri_claim_block: assert property (s_pri_bad ##0 cmd_q[CMD_PERR_BIT]
    |=> !primary_device_select_o) else $error("bad primary address claimed");
  a_pri_claim_plain: assert property (s_pri_bad ##0 !cmd_q[CMD_PERR_BIT]
    |=> primary_device_select_o) else $error("primary claim lost");
  a_sec_claim_block: assert property (s_sec_bad ##0 bc_q[BC_PERR_BIT]
    |=> !secondary_device_select_o) else $error("bad secondary address claimed");
  a_pri_addr_serr: assert property (s_pri_bad ##0 (cmd_q[CMD_SERR_BIT] &&
    cmd_q[CMD_PERR_BIT]) |=> primary_system_error_pin_o) else $error("no serr, pri");
  a_sec_addr_serr: assert property (s_sec_bad ##0 (cmd_q[CMD_SERR_BIT] &&
    bc_q[BC_PERR_BIT]) |=> primary_system_error_pin_o) else $error("no serr, sec");
  a_serr_forward: assert property (sec_serr_i && cmd_q[CMD_SERR_BIT] &&
    bc_q[BC_SERR_BIT] |=> primary_system_error_pin_o) else $error("serr not forwarded");
  a_serr_gate: assert property (primary_system_error_pin_o
    |-> $past(cmd_q[CMD_SERR_BIT])) else $error("serr while disabled");
  a_perr_data: assert property (dbad && cmd_q[CMD_PERR_BIT] |=> perr_o)
    else $error("perr missing");
  a_perr_cause: assert property (perr_o |-> $past(dbad))
    else $error("perr without bad data");
endmodule
bind bridge_err_report bridge_err_checker i_chk (.*);
`default_nettype wire

// [test/pci_bus_model.sv]
// far-side bus agents: address and data phases, secondary serr, engine events
`timescale 1ns/1ps
`default_nettype none
module pci_bus_model #(
  parameter logic [35:0] PAT = 36'h5a3c0f1e2
) (
  input  wire logic  clk_i,
  output logic [35:0] pri_phase_o,
  output logic [35:0] sec_phase_o,
  output logic        pri_par_o,
  output logic        sec_par_o,
  output logic        pri_addr_valid_o,
  output logic        pri_data_valid_o,
  output logic        pri_hit_o,
  output logic        sec_addr_valid_o,
  output logic        sec_hit_o,
  output logic        sec_serr_o,
  output logic [6:0]  fwd_event_o
);
  initial
  begin
    {pri_phase_o, sec_phase_o, pri_par_o, sec_par_o} = '0;
    {pri_addr_valid_o, pri_data_valid_o, pri_hit_o, sec_addr_valid_o} = '0;
    {sec_hit_o, sec_serr_o, fwd_event_o} = '0;
  end
  // k: 0 primary address, 1 secondary address, 2 primary data; bad makes parity odd
  task send(input int k, input logic bad);
    @(posedge clk_i);
    pri_phase_o <= PAT;
    sec_phase_o <= PAT;
    pri_par_o <= ^PAT ^ bad;
    sec_par_o <= ^PAT ^ bad;
    pri_addr_valid_o <= k == 0;
    pri_hit_o <= k == 0;
    pri_data_valid_o <= k == 2;
    sec_addr_valid_o <= k == 1;
    sec_hit_o <= k == 1;
    @(posedge clk_i);
    {pri_addr_valid_o, pri_hit_o, pri_data_valid_o, sec_addr_valid_o, sec_hit_o} <= '0;
    // released lines show the inverse so a stale sample never looks valid
    pri_phase_o <= ~PAT;
    sec_phase_o <= ~PAT;
  endtask
  task pulse(input logic [6:0] ev, input logic serr);
    @(posedge clk_i);
    fwd_event_o <= ev;
    sec_serr_o <= serr;
    @(posedge clk_i);
    fwd_event_o <= 7'h00;
    sec_serr_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [test/tb_bridge_err_report.sv]
// testbench: register access over ahb-lite and error scenarios on both buses
`timescale 1ns/1ps
`default_nettype none
module tb_bridge_err_report;
  import bridge_err_pkg::*;
  localparam logic [35:0] PAT = 36'h5a3c0f1e2;
  logic clk_i = 1'b0, rst_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, dr_head_i = 1'b0;
  logic [9:0] haddr_i = 10'h000;
  logic [1:0] htrans_i = 2'b00;
  logic [2:0] hsize_i = 3'b010;
  logic [31:0] hwdata_i = 32'h0, hrdata_o, rdat;
  logic [35:0] pri_phase_i, sec_phase_i;
  logic [6:0] fwd_event_i;
  logic hreadyout_o, hresp_o, pri_par_i, pri_addr_valid_i, pri_data_valid_i, pri_hit_i;
  logic sec_par_i, sec_addr_valid_i, sec_hit_i, sec_serr_i, perr_o, fwd_par_o;
  logic primary_device_select_o, secondary_device_select_o, primary_system_error_pin_o;
  logic dr_discard_o, irq_o;
  wire logic hready_i = hreadyout_o;
  logic pri_master_i = 1'b0, pri_perr_seen_i = 1'b0, dr_repeat_i = 1'b0;
  int n_fail = 0, n_compared = 0, cyc = 0, n;
  bridge_err_report #(.DISCARD_SHORT(8), .DISCARD_LONG(16)) i_dut (.*);
  pci_bus_model #(.PAT(PAT)) i_bus (.clk_i(clk_i), .pri_phase_o(pri_phase_i),
    .sec_phase_o(sec_phase_i), .pri_par_o(pri_par_i), .sec_par_o(sec_par_i),
    .pri_addr_valid_o(pri_addr_valid_i), .pri_data_valid_o(pri_data_valid_i),
    .pri_hit_o(pri_hit_i), .sec_addr_valid_o(sec_addr_valid_i), .sec_hit_o(sec_hit_i),
    .sec_serr_o(sec_serr_i), .fwd_event_o(fwd_event_i));
  always #2.5 clk_i = ~clk_i;
  task report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      report_and_stop;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= HTRANS_NONSEQ;
    haddr_i <= {a, 2'b00};
    hwrite_i <= w;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    rdat = hrdata_o;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(32'(hresp_o), 32'h0);
    chk(rdat, exp);
  endtask
  // clearing primary, secondary and event status with ones; the task only writes and reads nothing back to check the sticky bits drop
  task clr;
    ahb(1'b1, OFF_PRI_STATUS, 32'hffff);
    ahb(1'b1, OFF_SEC_STATUS, 32'hffff);
    ahb(1'b1, OFF_EVENT_STAT, 32'hff);
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    i_bus.send(0, 1'b0);
    i_bus.send(1, 1'b0);
    rd(OFF_COMMAND, 32'h0);
    rd(OFF_EVENT_MASK, 32'h0);
    rd(OFF_BRIDGE_CTRL, 32'h0);
    rd(8'h10, 32'h0);
    ahb(1'b1, OFF_IRQ_MASK, 32'h1);
    i_bus.send(0, 1'b1);
    repeat (3) @(posedge clk_i);
    chk(32'(irq_o), 32'h1);
    rd(OFF_PRI_STATUS, 32'h8000);
    rd(OFF_IRQ_STATUS, 32'h1);
    ahb(1'b1, OFF_IRQ_STATUS, 32'h1f);
    clr;
    rd(OFF_PRI_STATUS, 32'h0);
    chk(32'(irq_o), 32'h0);
    ahb(1'b1, OFF_IRQ_MASK, 32'h0);
    ahb(1'b1, OFF_COMMAND, 32'h0140);
    i_bus.send(0, 1'b1);
    rd(OFF_PRI_STATUS, 32'hc000);
    chk(32'(irq_o), 32'h0);
    clr;
    i_bus.send(2, 1'b1);
    rd(OFF_PRI_STATUS, 32'h8100);
    chk(32'(fwd_par_o), 32'(~^PAT));
    clr;
    pri_master_i <= 1'b1;
    pri_perr_seen_i <= 1'b1;
    @(posedge clk_i);
    pri_master_i <= 1'b0;
    pri_perr_seen_i <= 1'b0;
    rd(OFF_PRI_STATUS, 32'h0100);
    ahb(1'b1, OFF_BRIDGE_CTRL, 32'h3);
    clr;
    i_bus.send(1, 1'b1);
    rd(OFF_SEC_STATUS, 32'h8000);
    rd(OFF_PRI_STATUS, 32'h4000);
    clr;
    i_bus.pulse(7'h00, 1'b1);
    rd(OFF_SEC_STATUS, 32'h4000);
    rd(OFF_PRI_STATUS, 32'h4000);
    for (int i = 0; i < NUM_EVENTS; i++)
    begin
      clr;
      i_bus.pulse(7'(1 << i), 1'b0);
      rd(OFF_EVENT_STAT, 32'(1 << i));
      rd(OFF_PRI_STATUS, 32'h4000);
    end
    ahb(1'b1, OFF_EVENT_MASK, 32'h7f);
    clr;
    i_bus.pulse(7'h7f, 1'b0);
    rd(OFF_PRI_STATUS, 32'h0);
    ahb(1'b1, OFF_EVENT_MASK, 32'h0);
    clr;
    dr_head_i <= 1'b1;
    n = 0;
    while (dr_discard_o !== 1'b1 && n < 40)
    begin
      @(posedge clk_i);
      n++;
    end
    dr_head_i <= 1'b0;
    chk(32'(n > 10 && n < 22), 32'h1);
    rd(OFF_EVENT_STAT, 32'h40);
    // a repeated request restarts the timer, so no discard may follow
    clr;
    dr_head_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    dr_repeat_i <= 1'b1;
    @(posedge clk_i);
    dr_repeat_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    dr_head_i <= 1'b0;
    rd(OFF_EVENT_STAT, 32'h0);
    report_and_stop;
  end
endmodule
`default_nettype wire
